// ==== src/vps_pkg.sv ====
package vps_pkg;
  // clock and time base
  localparam int CLK_NS      = 8;
  localparam int TICK_NS     = 10_000_000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int NSTG        = 6;
  localparam int VW          = 11;
  localparam int TW          = 15;
  localparam int PW          = 7;
  localparam int CW          = 16;
  localparam logic [PW-1:0] PCT_FULL = 7'h64;
  // voltages in 0.1 % of nominal, times in 10 ms steps
  localparam logic [VW-1:0] OV_THR_MIN  = 11'h01F4;
  localparam logic [VW-1:0] OV1_THR_MAX = 11'h05DC;
  localparam logic [VW-1:0] OV_THR_MAX  = 11'h0640;
  localparam logic [VW-1:0] UV_THR_MIN  = 11'h00C8;
  localparam logic [VW-1:0] UV_THR_MAX  = 11'h04B0;
  localparam logic [VW-1:0] HYST_MIN    = 11'h0001;
  localparam logic [VW-1:0] HYST_MAX    = 11'h00C8;
  localparam logic [VW-1:0] SBL_MAX     = 11'h0320;
  localparam logic [TW-1:0] OP_MIN      = 15'h0008;
  localparam logic [TW-1:0] OP3_MIN     = 15'h0006;
  localparam logic [TW-1:0] HOLD_MIN    = 15'h0006;
  localparam logic [TW-1:0] TIME_MAX    = 15'h7530;
  // values after reset
  localparam logic [VW-1:0] OV1_THR_RST = 11'h04B0;
  localparam logic [VW-1:0] OV_THR_RST  = 11'h0514;
  localparam logic [VW-1:0] UV1_THR_RST = 11'h0320;
  localparam logic [VW-1:0] UV_THR_RST  = 11'h02BC;
  localparam logic [TW-1:0] OV1_OP_RST  = 15'h0014;
  localparam logic [TW-1:0] OV_OP_RST   = 15'h000A;
  localparam logic [TW-1:0] UV1_OP_RST  = 15'h07D0;
  localparam logic [TW-1:0] UV_OP_RST   = 15'h00C8;
  localparam logic [TW-1:0] HOLD_RST    = 15'h0006;
  localparam logic [VW-1:0] HYST_RST    = 11'h000A;
  localparam logic [VW-1:0] SBL_RST     = 11'h0064;
  localparam logic [3:0]    MASK_RST    = 4'hF;
  // register map: stage s at s*0x20, globals in slot 6
  localparam logic [2:0] F_THR   = 3'h0;
  localparam logic [2:0] F_OP    = 3'h1;
  localparam logic [2:0] F_HOLD  = 3'h2;
  localparam logic [2:0] F_HYST  = 3'h3;
  localparam logic [2:0] F_MASK  = 3'h4;
  localparam logic [2:0] F_STAT  = 3'h5;
  localparam logic [2:0] F_TALLY = 3'h6;
  localparam logic [2:0] F_REC   = 3'h7;
  localparam logic [2:0] G_SLOT  = 3'h6;
  localparam logic [2:0] G_CFG   = 3'h0;
  localparam logic [2:0] G_MEAS  = 3'h1;

  function automatic logic [VW-1:0] clampv(logic [VW-1:0] v, logic [VW-1:0] lo, logic [VW-1:0] hi);
    clampv = (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction : clampv

  function automatic logic [TW-1:0] clampt(logic [TW-1:0] v, logic [TW-1:0] lo, logic [TW-1:0] hi);
    clampt = (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction : clampt
endpackage : vps_pkg

// ==== src/vps_top.sv ====
`timescale 1ns/1ps
// What this block does
// - three independent overvoltage stages, each with own threshold and operate time
// - one measured input, symmetric derivation, definite-time operation only
// - overvoltage start when voltage exceeds threshold; ranges 50-150 and 50-160 %
// - overvoltage trip once the fault lasts the full operate time
// - start delay is fixed; delayed alarm comes from using a trip as alarm
// - first overvoltage stage clears its timer only after the hold time
// - fault returning inside hold time resumes from the accumulated time
// - operate time 0.08-300 s; third stage allows 0.06 s
// - only first overvoltage stage has a hold time, 0.06-300 s
// - three independent undervoltage stages, each with own threshold and time
// - undervoltage start when voltage falls below threshold; range 20-120 %
// - undervoltage trip once the fault lasts the configured delay
// - first undervoltage stage holds and resumes its timer like the overvoltage one
// - only first undervoltage stage has a hold time, 0.06-300 s
// - external block input inhibits all undervoltage stages
// - a configurable internal block source inhibits undervoltage stages
// - voltage below self-block level blocks undervoltage; 0-80 %, default 10 %
// - per-stage start and trip tallies, readable
// - fault value: maximum for overvoltage, minimum for undervoltage
// - elapsed operate time in percent, 100 means trip
// - measured value: highest line voltage and lowest line voltage
module vps_top #(
  parameter int TICK_DIV = vps_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        NRST_I,
  // wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  // measurement and blocking
  input  wire logic [10:0] VOLT_I,
  input  wire logic        EXT_BLK_I,
  input  wire logic [3:0]  INT_BLK_I,
  // stage outputs
  output logic      [5:0]  START_O,
  output logic      [5:0]  TRIP_O,
  output logic      [23:0] EVT_O
);
  localparam int N  = vps_pkg::NSTG;
  localparam int VW = vps_pkg::VW;
  localparam int TW = vps_pkg::TW;
  localparam int CW = vps_pkg::CW;

  logic [1:0]    rst_pipe;
  logic          rst_n;
  logic [31:0]   tick_cnt;
  logic          tick;
  logic          ack;
  logic [31:0]   dat;
  logic [VW-1:0] thr   [N];
  logic [TW-1:0] op    [N];
  logic [TW-1:0] hold  [N];
  logic [VW-1:0] hyst  [N];
  logic [3:0]    emask [N];
  logic [TW-1:0] acc   [N];
  logic [TW-1:0] holdc [N];
  logic [CW-1:0] stally[N];
  logic [CW-1:0] ttally[N];
  logic [VW-1:0] fault [N];
  logic [6:0]    epct  [N];
  logic [5:0]    start;
  logic [5:0]    trip;
  logic [23:0]   evt;
  logic          in_ll;
  logic [2:0]    iblk_sel;
  logic [VW-1:0] sbl;
  logic [VW-1:0] vmeas;
  logic          uv_blk;

  // reset release through two flops
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) rst_pipe <= 2'h0;
    else rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_n = rst_pipe[1];

  // 10 ms time base for every stage timer
  assign tick = (tick_cnt == 32'(TICK_DIV - 1));
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) tick_cnt <= 32'h0000_0000;
    else tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
  end

  // bus decode
  wire        req    = CYC_I && STB_I && !ack;
  wire        wr     = req && WE_I;
  wire [2:0]  slot   = ADR_I[7:5];
  wire [2:0]  fld    = ADR_I[4:2];
  wire        in_stg = (slot < 3'(N));
  wire        in_gl  = (slot == vps_pkg::G_SLOT);
  wire [31:0] bmask  = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
  wire [2:0]  si     = in_stg ? slot : 3'h0;
  wire        s_first = (si == 3'h0) || (si == 3'h3);
  logic [31:0] rd_word;
  wire [31:0] wd     = (rd_word & ~bmask) | (DAT_I & bmask);

  wire [31:0] rd_stg =
    (fld == vps_pkg::F_THR)   ? 32'(thr[si]) :
    (fld == vps_pkg::F_OP)    ? 32'(op[si]) :
    (fld == vps_pkg::F_HOLD)  ? (s_first ? 32'(hold[si]) : 32'h0000_0000) :
    (fld == vps_pkg::F_HYST)  ? (s_first ? 32'(hyst[si]) : 32'h0000_0000) :
    (fld == vps_pkg::F_MASK)  ? 32'(emask[si]) :
    (fld == vps_pkg::F_STAT)  ? {29'h0000_0000, (si > 3'h2) && uv_blk, trip[si], start[si]} :
    (fld == vps_pkg::F_TALLY) ? {ttally[si], stally[si]} :
    {9'h000, epct[si], 5'h00, fault[si]};
  wire [31:0] rd_gl =
    (fld == vps_pkg::G_CFG)  ? {5'h00, sbl, 12'h000, iblk_sel, in_ll} :
    (fld == vps_pkg::G_MEAS) ? {5'h00, vmeas, 5'h00, vmeas} : 32'h0000_0000;
  assign rd_word = in_stg ? rd_stg : in_gl ? rd_gl : 32'h0000_0000;

  // one wait state answer, unmapped reads give zero
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      dat <= 32'h0000_0000;
    end else begin
      ack <= req;
      if (req) dat <= rd_word;
    end
  end
  assign ACK_O = ack;
  assign DAT_O = dat;

  // settings, clamped into range on write
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      in_ll    <= 1'b0;
      iblk_sel <= 3'h0;
      sbl      <= vps_pkg::SBL_RST;
      for (int s = 0; s < N; s++) begin
        thr[s]   <= (s == 0) ? vps_pkg::OV1_THR_RST : (s < 3) ? vps_pkg::OV_THR_RST :
                    (s == 3) ? vps_pkg::UV1_THR_RST : vps_pkg::UV_THR_RST;
        op[s]    <= (s == 0) ? vps_pkg::OV1_OP_RST : (s < 3) ? vps_pkg::OV_OP_RST :
                    (s == 3) ? vps_pkg::UV1_OP_RST : vps_pkg::UV_OP_RST;
        hold[s]  <= vps_pkg::HOLD_RST;
        hyst[s]  <= vps_pkg::HYST_RST;
        emask[s] <= vps_pkg::MASK_RST;
      end
    end else if (wr && in_gl && fld == vps_pkg::G_CFG) begin
      in_ll    <= wd[0];
      iblk_sel <= wd[3:1];
      sbl      <= (wd[26:16] > vps_pkg::SBL_MAX) ? vps_pkg::SBL_MAX : wd[26:16];
    end else if (wr && in_stg) begin
      for (int s = 0; s < N; s++) begin
        if (si == 3'(s)) begin
          case (fld)
            vps_pkg::F_THR:
              thr[s] <= (s < 3) ? vps_pkg::clampv(wd[10:0], vps_pkg::OV_THR_MIN,
                                    (s == 0) ? vps_pkg::OV1_THR_MAX : vps_pkg::OV_THR_MAX)
                                : vps_pkg::clampv(wd[10:0], vps_pkg::UV_THR_MIN, vps_pkg::UV_THR_MAX);
            vps_pkg::F_OP:
              op[s] <= vps_pkg::clampt(wd[14:0], (s % 3 == 2) ? vps_pkg::OP3_MIN : vps_pkg::OP_MIN,
                                       vps_pkg::TIME_MAX);
            vps_pkg::F_HOLD:
              if (s % 3 == 0) hold[s] <= vps_pkg::clampt(wd[14:0], vps_pkg::HOLD_MIN,
                                                         vps_pkg::TIME_MAX);
            vps_pkg::F_HYST:
              if (s % 3 == 0) hyst[s] <= vps_pkg::clampv(wd[10:0], vps_pkg::HYST_MIN,
                                                         vps_pkg::HYST_MAX);
            vps_pkg::F_MASK:
              emask[s] <= wd[3:0];
            default: ;
          endcase
        end
      end
    end
  end

  // symmetric supply: the derived line value equals the one measured
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) vmeas <= 11'h000;
    else vmeas <= VOLT_I;
  end

  // undervoltage inhibit sources
  wire int_blk = (iblk_sel != 3'h0) && (iblk_sel < 3'h5) && INT_BLK_I[2'(iblk_sel - 3'h1)];
  wire self_blk = (VOLT_I < sbl);
  assign uv_blk = EXT_BLK_I || int_blk || self_blk;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_stage
      localparam bit OV    = (g < 3);
      localparam bit FIRST = (g % 3 == 0);
      wire [11:0] hy   = (FIRST && start[g]) ? {1'b0, hyst[g]} : 12'h000;
      wire [11:0] lim  = OV ? ({1'b0, thr[g]} - hy) : ({1'b0, thr[g]} + hy);
      wire        cond = OV ? ({1'b0, VOLT_I} > lim) : ({1'b0, VOLT_I} < lim);
      wire        blk  = !OV && uv_blk;
      wire        next_start = cond && !blk;
      wire        next_trip  = next_start && (acc[g] >= op[g]);
      wire        clr_tally  = wr && in_stg && (si == 3'(g)) && (fld == vps_pkg::F_TALLY);
      wire        s_rise = next_start && !start[g];
      wire        t_rise = next_trip && !trip[g];
      wire [21:0] pct  = 22'((22'(acc[g]) * 22'(vps_pkg::PCT_FULL)) / 22'(op[g]));

      always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
          start[g]  <= 1'b0;
          trip[g]   <= 1'b0;
          acc[g]    <= 15'h0000;
          holdc[g]  <= 15'h0000;
          stally[g] <= 16'h0000;
          ttally[g] <= 16'h0000;
          fault[g]  <= 11'h000;
          epct[g]   <= 7'h00;
          evt[4*g +: 4] <= 4'h0;
        end else begin
          start[g] <= next_start;
          trip[g]  <= next_trip;
          evt[4*g +: 4] <= emask[g] & {!next_trip && trip[g], t_rise,
                                       !next_start && start[g], s_rise};
          if (blk) begin
            acc[g]   <= 15'h0000;
            holdc[g] <= 15'h0000;
          end else if (start[g]) begin
            holdc[g] <= 15'h0000;
            if (tick && acc[g] < op[g]) acc[g] <= acc[g] + 15'h0001;
          end else if (FIRST && acc[g] != 15'h0000) begin
            if (tick) begin
              if (holdc[g] + 15'h0001 >= hold[g]) begin
                acc[g]   <= 15'h0000;
                holdc[g] <= 15'h0000;
              end else holdc[g] <= holdc[g] + 15'h0001;
            end
          end else begin
            acc[g]   <= 15'h0000;
            holdc[g] <= 15'h0000;
          end
          // a count in the same cycle as a clear restarts the tally at one
          if (s_rise) stally[g] <= clr_tally ? 16'h0001 : stally[g] + 16'h0001;
          else if (clr_tally) stally[g] <= 16'h0000;
          if (t_rise) ttally[g] <= clr_tally ? 16'h0001 : ttally[g] + 16'h0001;
          else if (clr_tally) ttally[g] <= 16'h0000;
          if (s_rise) fault[g] <= VOLT_I;
          else if (start[g] && (OV ? VOLT_I > fault[g] : VOLT_I < fault[g])) fault[g] <= VOLT_I;
          if (start[g]) epct[g] <= (pct > 22'(vps_pkg::PCT_FULL)) ? vps_pkg::PCT_FULL : pct[6:0];
        end
      end
    end
  endgenerate

  assign START_O = start;
  assign TRIP_O  = trip;
  assign EVT_O   = evt;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n);

  wire clr_tally0 = g_stage[0].clr_tally;
  wire clr_tally1 = g_stage[1].clr_tally;

  a_trip_has_start: assert property (trip[1] |-> start[1])
    else $error("trip without start");
  a_ov_start_rise: assert property (!start[1] && (VOLT_I > thr[1]) |=> start[1])
    else $error("overvoltage start missed");
  a_uv_ext_block: assert property (EXT_BLK_I |=> !start[4] && !start[5] && !start[3])
    else $error("undervoltage start while blocked");
  a_self_block: assert property ((VOLT_I < sbl) |=> !start[3])
    else $error("self block ignored");
  a_plain_reset: assert property (!start[1] |=> acc[1] == 15'h0000)
    else $error("second stage timer kept");
  a_hold_keeps: assert property (!start[0] && acc[0] != 15'h0000 && !tick
                                 |=> acc[0] == $past(acc[0]))
    else $error("first stage timer lost early");
  a_trip_time: assert property ($rose(trip[2]) |-> $past(acc[2]) >= op[2])
    else $error("trip before operate time");
  a_tally_step: assert property ($rose(start[1]) && !$past(clr_tally1) |->
                                 stally[1] == $past(stally[1]) + 16'h0001)
    else $error("start tally not counted");
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack held over two cycles");
  // bus answer
  a_bus_answer: assert property (req |=> ack)
    else $error("request not answered");

  // overvoltage timers and records
  a_ov3_trip_start: assert property (trip[2] |-> start[2])
    else $error("third stage trip without start");
  a_resume_acc: assert property (start[0] && tick && (acc[0] < op[0])
                                 |=> acc[0] == $past(acc[0]) + 15'h0001)
    else $error("first stage timer not counting");
  a_hold_expiry: assert property (!start[0] && tick && acc[0] != 15'h0000 && (holdc[0] + 15'h0001 >= hold[0])
                                  |=> acc[0] == 15'h0000)
    else $error("first stage timer kept past hold");
  a_evt_start_on: assert property ($rose(start[0]) |-> evt[0] == $past(emask[0][0]))
    else $error("start on event wrong");
  a_evt_trip_pulse: assert property (evt[2] |=> !evt[2])
    else $error("trip event longer than a cycle");
  a_tally_trip: assert property ($rose(trip[0]) && !$past(clr_tally0) |->
                                 ttally[0] == $past(ttally[0]) + 16'h0001)
    else $error("trip tally not counted");
  a_epct_full: assert property (trip[0] && acc[0] >= op[0] |=> epct[0] == vps_pkg::PCT_FULL)
    else $error("elapsed percent not full at trip");
  a_fault_max: assert property (start[0] |=> fault[0] >= $past(VOLT_I))
    else $error("overvoltage fault value below input");
  a_trip_off_evt: assert property ($fell(trip[0]) |-> evt[3] == $past(emask[0][3]))
    else $error("trip off event wrong");
  a_ov2_no_hold: assert property (holdc[1] == 15'h0000)
    else $error("second stage hold counter moved");
  a_ov_thr_range: assert property (thr[0] >= vps_pkg::OV_THR_MIN && thr[0] <= vps_pkg::OV1_THR_MAX)
    else $error("first stage threshold out of range");
  a_ov1_op_range: assert property (op[0] >= vps_pkg::OP_MIN)
    else $error("first stage operate time too short");

  // undervoltage; hold check skips blocked cycles, since blocking clears the timer
  a_uv_trip_start: assert property (trip[4] |-> start[4])
    else $error("undervoltage trip without start");
  a_uv_fall_start: assert property (!start[4] && !uv_blk && (VOLT_I < thr[4])
                                    |=> start[4])
    else $error("undervoltage start missed");
  a_uv_int_block: assert property (int_blk |=> !start[3] && !start[4] && !start[5])
    else $error("internal block ignored");
  a_uv_self_all: assert property (self_blk |=> !start[4] && !start[5])
    else $error("self block ignored on later stages");
  a_uv_hold_keeps: assert property (!start[3] && !uv_blk && acc[3] != 15'h0000 && !tick
                                    |=> acc[3] == $past(acc[3]))
    else $error("undervoltage timer lost early");
  a_uv_trip_time: assert property ($rose(trip[4]) |-> $past(acc[4]) >= $past(op[4]))
    else $error("undervoltage trip before delay");
  a_uv2_plain: assert property (!start[4] |=> acc[4] == 15'h0000)
    else $error("second undervoltage timer kept");
  a_fault_min: assert property (start[3] |=> fault[3] <= $past(VOLT_I))
    else $error("undervoltage fault value above input");
  a_uv_off_evt: assert property ($fell(start[3]) |-> evt[13] == $past(emask[3][1]))
    else $error("start off event wrong");
  a_sbl_range: assert property (sbl <= vps_pkg::SBL_MAX)
    else $error("self block level out of range");
  a_meas_follow: assert property ($past(rst_n) |-> vmeas == $past(VOLT_I))
    else $error("measured value stale");
endmodule : vps_top

// ==== tb/vps_front.sv ====
`timescale 1ns/1ps
// measurement front end: single input in 0.1 % of nominal, small ripple, fixed lag
module vps_front #(
  parameter int LAG = 2
) (
  // clock
  input  wire logic        clk_i,
  // commanded line level and blocking sources
  input  wire logic [10:0] level_i,
  input  wire logic [1:0]  ripple_i,
  input  wire logic        ext_i,
  input  wire logic [3:0]  int_i,
  // toward the protection block
  output logic      [10:0] volt_o,
  output logic             ext_o,
  output logic      [3:0]  int_o
);
  logic [10:0] pipe [LAG];

  // ripple stays far inside every threshold margin, so it never decides an outcome
  always_ff @(posedge clk_i) begin
    pipe[0] <= level_i + {9'h000, ripple_i};
    for (int i = 1; i < LAG; i++) begin
      pipe[i] <= pipe[i-1];
    end
    ext_o <= ext_i;
    int_o <= int_i;
  end

  assign volt_o = pipe[LAG-1];
endmodule : vps_front

// ==== tb/vps_top_tb.sv ====
`timescale 1ns/1ps
module vps_top_tb;
  typedef struct {logic chk; logic [31:0] exp; string nm;} vps_note_t;
  logic        CLK_I, NRST_I, CYC_I, STB_I, WE_I, ACK_O, EXT_BLK_I, ext, rip_on;
  logic [7:0]  ADR_I;
  logic [31:0] DAT_I, DAT_O, rv;
  logic [31:0] seed = 32'h0000_dd3e;
  logic [10:0] VOLT_I, level;
  logic [3:0]  INT_BLK_I, intb;
  logic [1:0]  ripple;
  logic [5:0]  START_O, TRIP_O;
  logic [23:0] EVT_O;
  logic [7:0]  ca [6];
  logic [31:0] cw [6], ce [6], cr [6];
  int          evt_cnt [24] = '{default: 0};
  int          error_cnt, total_checks;
  vps_note_t   notes [$];
  vps_note_t   note;

  vps_top #(.TICK_DIV(10)) dut (.CLK_I(CLK_I), .NRST_I(NRST_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
    .ADR_I(ADR_I), .SEL_I(4'hF), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .VOLT_I(VOLT_I),
    .EXT_BLK_I(EXT_BLK_I), .INT_BLK_I(INT_BLK_I), .START_O(START_O), .TRIP_O(TRIP_O), .EVT_O(EVT_O));
  vps_front #(.LAG(2)) front (.clk_i(CLK_I), .level_i(level), .ripple_i(ripple), .ext_i(ext),
    .int_i(intb), .volt_o(VOLT_I), .ext_o(EXT_BLK_I), .int_o(INT_BLK_I));

  initial begin
    CLK_I = 1'b0;
    forever #4 CLK_I = ~CLK_I;
  end

  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  function automatic logic [7:0] ra(int s, logic [2:0] f);
    return {s[2:0], f, 2'b00};
  endfunction : ra

  task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // one classic cycle; the note is queued before the request so the monitor always finds it
  task automatic wb(logic we, logic [7:0] a, logic [31:0] d, logic chk, string nm);
    int n;
    n = 0;
    notes.push_back('{chk, d, nm});
    @(posedge CLK_I);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= we;
    ADR_I <= a;
    DAT_I <= we ? d : 32'h0000_0000;
    do begin
      @(posedge CLK_I);
      n++;
    end while (ACK_O !== 1'b1 && n < 50);
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    WE_I <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      close_out();
    end
  endtask : wb

  task automatic rd(logic [7:0] a, logic [31:0] e, string nm);
    wb(1'b0, a, e, 1'b1, nm);
  endtask : rd

  task automatic wr(logic [7:0] a, logic [31:0] d);
    wb(1'b1, a, d, 1'b0, "write");
  endtask : wr

  always @(posedge CLK_I) begin
    seed <= xs(seed);
    ripple <= rip_on ? seed[1:0] : 2'b00;
    for (int i = 0; i < 24; i++) begin
      if (EVT_O[i] === 1'b1) evt_cnt[i] <= evt_cnt[i] + 1;
    end
    if (ACK_O === 1'b1) begin
      if (notes.size() == 0) check("spurious ack", 32'h0000_0000, 32'h0000_0001);
      else begin
        note = notes.pop_front();
        if (note.chk) check(note.nm, note.exp, DAT_O);
      end
    end
  end

  initial begin
    {NRST_I, CYC_I, STB_I, WE_I, ADR_I, DAT_I, ext, intb, rip_on} = '0;
    level = 11'h3E8;
    repeat (20) @(posedge CLK_I);
    NRST_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    for (int s = 0; s < 6; s++) begin
      rd(ra(s, vps_pkg::F_THR), 32'(s == 0 ? vps_pkg::OV1_THR_RST : s < 3 ? vps_pkg::OV_THR_RST :
        s == 3 ? vps_pkg::UV1_THR_RST : vps_pkg::UV_THR_RST), "thr");
      rd(ra(s, vps_pkg::F_OP), 32'(s == 0 ? vps_pkg::OV1_OP_RST : s < 3 ? vps_pkg::OV_OP_RST :
        s == 3 ? vps_pkg::UV1_OP_RST : vps_pkg::UV_OP_RST), "op");
      rd(ra(s, vps_pkg::F_MASK), 32'h0000_000F, "mask");
    end
    rd(ra(6, vps_pkg::G_CFG), 32'h0064_0000, "cfg");
    $display("test reset values done");
    ca = '{ra(0, vps_pkg::F_THR), ra(3, vps_pkg::F_THR), ra(1, vps_pkg::F_OP), ra(2, vps_pkg::F_OP),
      ra(0, vps_pkg::F_HOLD), ra(6, vps_pkg::G_CFG)};
    cw = '{32'h0000_07FF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_7FFF, 32'h07FF_0000};
    ce = '{32'h0000_05DC, 32'h0000_00C8, 32'h0000_0008, 32'h0000_0006, 32'h0000_7530, 32'h0320_0000};
    cr = '{32'h0000_04B0, 32'h0000_0320, 32'h0000_000A, 32'h0000_000A, 32'h0000_0006, 32'h0064_0004};
    for (int i = 0; i < 6; i++) begin
      wr(ca[i], cw[i]);
      rd(ca[i], ce[i], "clamp");
      wr(ca[i], cr[i]);
    end
    rv = 32'd1201 + (seed % 32'd400);
    wr(ra(1, vps_pkg::F_THR), rv);
    rd(ra(1, vps_pkg::F_THR), rv, "thr random");
    wr(ra(1, vps_pkg::F_THR), 32'h0000_0514);
    wr(8'hE0, 32'hFFFF_FFFF);
    rd(8'hE0, 32'h0000_0000, "unmapped");
    wr(ra(0, vps_pkg::F_STAT), 32'h0000_0007);
    rd(ra(0, vps_pkg::F_STAT), 32'h0000_0000, "status ro");
    wr(ra(1, vps_pkg::F_MASK), 32'h0000_0000);
    $display("test registers done");
    level <= 11'h4E2;
    repeat (40) @(posedge CLK_I);
    rd(ra(0, vps_pkg::F_STAT), 32'h0000_0001, "ov start");
    repeat (260) @(posedge CLK_I);
    rd(ra(0, vps_pkg::F_STAT), 32'h0000_0003, "ov trip");
    rd(ra(1, vps_pkg::F_STAT), 32'h0000_0000, "ov2 idle");
    rd(ra(0, vps_pkg::F_REC), 32'h0064_04E2, "ov record");
    rd(ra(0, vps_pkg::F_TALLY), 32'h0001_0001, "tally");
    check("start pins", 32'h0000_0001, 32'(START_O));
    check("trip pins", 32'h0000_0001, 32'(TRIP_O));
    level <= 11'h4AB;
    repeat (20) @(posedge CLK_I);
    rd(ra(0, vps_pkg::F_STAT), 32'h0000_0003, "hysteresis");
    level <= 11'h3E8;
    repeat (150) @(posedge CLK_I);
    rd(ra(0, vps_pkg::F_STAT), 32'h0000_0000, "ov release");
    rd(ra(6, vps_pkg::G_MEAS), 32'h03E8_03E8, "measured");
    wr(ra(0, vps_pkg::F_TALLY), 32'h0000_0000);
    rd(ra(0, vps_pkg::F_TALLY), 32'h0000_0000, "tally clear");
    $display("test overvoltage done");
    rip_on <= 1'b1;
    // short faults: only the held timer of the first stage may add up to a trip
    for (int i = 0; i < 3; i++) begin
      level <= 11'h546;
      repeat (75) @(posedge CLK_I);
      rd(ra(0, vps_pkg::F_STAT), (i == 2) ? 32'h0000_0003 : 32'h0000_0001, "held timer");
      rd(ra(1, vps_pkg::F_STAT), 32'h0000_0001, "no hold");
      level <= 11'h3E8;
      repeat (25) @(posedge CLK_I);
    end
    rd(ra(0, vps_pkg::F_TALLY), 32'h0001_0003, "tally count");
    check("start on events", 32'd4, evt_cnt[0]);
    check("trip on events", 32'd2, evt_cnt[2]);
    check("masked events", 32'd0, evt_cnt[4]);
    check("start off events", 32'd4, evt_cnt[1]);
    check("trip off events", 32'd2, evt_cnt[3]);
    $display("test release delay done");
    wr(ra(4, vps_pkg::F_OP), 32'h0000_0008);
    level <= 11'h2EE;
    repeat (40) @(posedge CLK_I);
    rd(ra(3, vps_pkg::F_STAT), 32'h0000_0001, "uv start");
    rd(ra(4, vps_pkg::F_STAT), 32'h0000_0000, "uv2 idle");
    ext <= 1'b1;
    repeat (10) @(posedge CLK_I);
    rd(ra(3, vps_pkg::F_STAT), 32'h0000_0004, "ext block");
    ext <= 1'b0;
    intb <= 4'b0001;
    repeat (10) @(posedge CLK_I);
    rd(ra(3, vps_pkg::F_STAT), 32'h0000_0001, "other source");
    intb <= 4'b0010;
    repeat (10) @(posedge CLK_I);
    rd(ra(3, vps_pkg::F_STAT), 32'h0000_0004, "int block");
    intb <= 4'b0000;
    level <= 11'h28A;
    repeat (140) @(posedge CLK_I);
    rd(ra(4, vps_pkg::F_STAT), 32'h0000_0003, "uv trip");
    rd(ra(5, vps_pkg::F_STAT), 32'h0000_0001, "uv3 start");
    check("uv start pins", 32'h0000_0038, 32'(START_O));
    check("uv trip pins", 32'h0000_0010, 32'(TRIP_O));
    level <= 11'h032;
    repeat (10) @(posedge CLK_I);
    rd(ra(5, vps_pkg::F_STAT), 32'h0000_0004, "self block");
    level <= 11'h3E8;
    repeat (20) @(posedge CLK_I);
    $display("test undervoltage done");
    close_out();
  end
endmodule : vps_top_tb
